// ### verilog/svdc_pkg.sv
// Constants and types for the supply voltage detect control block
`default_nettype none

package svdc_pkg;

    // Register index as printed, byte address is four times it
    localparam logic [17:0] SVDC_CTRL_INDEX  = 18'h0FF12;
    localparam logic [19:0] SVDC_CTRL_ADDR   = {SVDC_CTRL_INDEX, 2'b00};
    localparam int          SVDC_ADDR_W      = 20;
    localparam int          SVDC_DATA_W      = 32;

    // Field positions in the control register
    localparam int          SVDC_AUTO_BIT    = 5;
    localparam int          SVDC_CONT_BIT    = 4;
    localparam int          SVDC_LEVEL_LSB   = 0;
    localparam int          SVDC_LEVEL_W     = 4;

    // Reset values
    localparam logic [3:0]  SVDC_LEVEL_RST   = 4'h0;
    localparam logic        SVDC_AUTO_RST    = 1'b0;
    localparam logic        SVDC_CONT_RST    = 1'b0;

    // Clock rate and timing figures
    localparam int          SVDC_CLK_HZ      = 25000000;
    localparam int          SVDC_DECISION_US = 7800;   // 7.8 ms
    localparam int          SVDC_AUTO_PER_S  = 4;      // 1/4 Hz
    // Decision time in whole cycles; the MHz factor truncates, nothing rounds up
    localparam int          SVDC_DECISION_CYC =
        (SVDC_DECISION_US * (SVDC_CLK_HZ / 1000000) + 0);
    localparam int          SVDC_AUTO_CYC    = SVDC_AUTO_PER_S * SVDC_CLK_HZ;

    // Software-held control fields
    typedef struct packed {
        logic auto_sample_enable;
        logic continuous_sample_on;
    } svdc_ctrl_t;

    // Sampling sequencer states
    typedef enum logic [1:0] {
        SVDC_IDLE = 2'b01,
        SVDC_CONV = 2'b10
    } svdc_state_t;

endpackage

`default_nettype wire

// ### verilog/svdc_top.sv
// Supply voltage detect control with Avalon-MM register slave
`default_nettype none

module svdc_top
    import svdc_pkg::*;
#(
    parameter int DECISION_CYC = SVDC_DECISION_CYC,
    parameter int AUTO_CYC     = SVDC_AUTO_CYC
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // Avalon-MM slave
    input  wire logic [SVDC_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [SVDC_DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output var  logic [SVDC_DATA_W-1:0] avs_readdata,
    output var  logic                   avs_waitrequest,
    // Analog detector side
    input  wire logic [3:0]             supply_level,
    output var  logic                   sense_enable,
    output var  logic [3:0]             detect_level,
    // Sleep entry from the core, same clock
    input  wire logic                   sleep_clear
);

    localparam int DW = (DECISION_CYC > 1) ? $clog2(DECISION_CYC) : 1;
    localparam int AW = (AUTO_CYC > 1) ? $clog2(AUTO_CYC) : 1;
    localparam logic [DW-1:0] DEC_LAST = DW'(DECISION_CYC - 1);
    localparam logic [AW-1:0] AUTO_LAST = AW'(AUTO_CYC - 1);

    svdc_ctrl_t    ctrl;
    svdc_state_t   state;
    logic [DW-1:0] dec_cnt;
    logic [AW-1:0] auto_cnt;
    logic          auto_tick;
    logic          auto_pend;
    logic          first_pend;
    logic [3:0]    level;
    logic [3:0]    lvl_meta;
    logic [3:0]    lvl_sync;
    logic          hit;
    logic          acc_write;
    logic          start_conv;
    logic          conv_done;
    logic          busy;
    logic [7:0]    ctrl_view;
    logic [SVDC_DATA_W-1:0] next_readdata;

    // Two-flop synchroniser for the analog level pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_meta <= 4'h0;
            lvl_sync <= 4'h0;
        end else begin
            lvl_meta <= supply_level;
            lvl_sync <= lvl_meta;
        end
    end

    // Address decode for the single control word
    always_comb begin
        if (avs_address == SVDC_CTRL_ADDR) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Write lands only at the edge that sees waitrequest low
    assign acc_write = avs_write && !avs_waitrequest && hit && avs_byteenable[0];

    // Bus handshake: one wait cycle, then a one-cycle acknowledge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Busy while any sampling runs or continuous mode holds the circuit on
    // first sample busy
    assign busy = first_pend || (state == SVDC_CONV) || ctrl.continuous_sample_on;

    // Register image; upper bits tie low
    // bits 7:6 zero
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[SVDC_AUTO_BIT] = ctrl.auto_sample_enable;
        ctrl_view[SVDC_CONT_BIT] = busy;
        ctrl_view[SVDC_LEVEL_LSB +: SVDC_LEVEL_W] = level;
    end

    // Unmapped reads answer zero
    always_comb begin
        if (hit) begin
            next_readdata = {24'h000000, ctrl_view};
        end else begin
            next_readdata = 32'h00000000;
        end
    end

    // Read data captured while waiting so it stands at the acknowledge edge
    // old level until update
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // Control bits; sleep entry forces both off and wins over a write
    // continuous on/off
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl.auto_sample_enable   <= SVDC_AUTO_RST;
            ctrl.continuous_sample_on <= SVDC_CONT_RST;
        end else if (sleep_clear) begin
            ctrl.auto_sample_enable   <= 1'b0;
            ctrl.continuous_sample_on <= 1'b0;
        end else if (acc_write) begin
            ctrl.auto_sample_enable   <= avs_writedata[SVDC_AUTO_BIT];
            ctrl.continuous_sample_on <= avs_writedata[SVDC_CONT_BIT];
        end
    end

    // Four-second divider, runs only while auto mode is on
    // four second tick
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_cnt  <= '0;
            auto_tick <= 1'b0;
        end else if (!ctrl.auto_sample_enable) begin
            auto_cnt  <= '0;
            auto_tick <= 1'b0;
        end else if (auto_cnt == AUTO_LAST) begin
            auto_cnt  <= '0;
            auto_tick <= 1'b1;
        end else begin
            auto_cnt  <= auto_cnt + 1'b1;
            auto_tick <= 1'b0;
        end
    end

    // Pending auto sample; a tick in the start cycle is kept
    // queue auto sample
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_pend <= 1'b0;
        end else if (auto_tick) begin
            auto_pend <= 1'b1;
        end else if (start_conv || !ctrl.auto_sample_enable) begin
            auto_pend <= 1'b0;
        end
    end

    // Start a conversion when idle and something asks for one
    assign start_conv = (state == SVDC_IDLE) &&
                        (first_pend || auto_pend || ctrl.continuous_sample_on);

    // End of decision time
    // decision time count
    assign conv_done = (state == SVDC_CONV) && (dec_cnt == DEC_LAST);

    // Sequencer; a running conversion always completes so the level
    // never holds a half-settled reading
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SVDC_IDLE;
        end else begin
            case (state)
                SVDC_IDLE: begin
                    if (start_conv) begin
                        state <= SVDC_CONV;
                    end
                end
                SVDC_CONV: begin
                    if (conv_done) begin
                        state <= SVDC_IDLE;
                    end
                end
                default: begin
                    state <= SVDC_IDLE;
                end
            endcase
        end
    end

    // Decision time counter
    // wait full time
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_cnt <= '0;
        end else if (state != SVDC_CONV) begin
            dec_cnt <= '0;
        end else if (!conv_done) begin
            dec_cnt <= dec_cnt + 1'b1;
        end
    end

    // First sample after reset is owed until its conversion ends
    // first sample
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_pend <= 1'b1;
        end else if (conv_done) begin
            first_pend <= 1'b0;
        end
    end

    // Level updates only at the end of a conversion
    // load first result
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= SVDC_LEVEL_RST;
        end else if (conv_done) begin
            level <= lvl_sync;
        end
    end

    // Registered copies for the analog side
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_enable <= 1'b0;
            detect_level <= SVDC_LEVEL_RST;
        end else begin
            sense_enable <= start_conv || ((state == SVDC_CONV) && !conv_done);
            detect_level <= conv_done ? lvl_sync : level;
        end
    end

endmodule

`default_nettype wire

// ### tb/svdc_asserts.sv
// Port checker for the supply detect control block
`default_nettype none
module svdc_chk
    import svdc_pkg::*;
#(parameter int DECISION_CYC = 20, parameter int AUTO_CYC = 50) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic [19:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Detector side and sleep entry from the core
    input wire logic [3:0]  supply_level,
    input wire logic        sense_enable,
    input wire logic [3:0]  detect_level,
    input wire logic        sleep_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] hi_cnt;
    logic [31:0] lo_cnt;
    logic        auto_sh;
    logic        cont_sh;
    wire logic   hit = avs_address == SVDC_CTRL_ADDR;
    wire logic   rd  = !avs_waitrequest && avs_read;
    wire logic   wr  = !avs_waitrequest && avs_write && hit && avs_byteenable[0];
    // Mode shadow and run lengths; sleep entry wins over a write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt  <= '0;
            lo_cnt  <= '0;
            auto_sh <= 1'b0;
            cont_sh <= 1'b0;
        end else begin
            hi_cnt <= sense_enable ? hi_cnt + 1 : '0;
            lo_cnt <= (sense_enable || wr) ? '0 : lo_cnt + 1;
            if (sleep_clear) begin
                auto_sh <= 1'b0;
                cont_sh <= 1'b0;
            end else if (wr) begin
                auto_sh <= avs_writedata[SVDC_AUTO_BIT];
                cont_sh <= avs_writedata[SVDC_CONT_BIT];
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_wait_state: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no acknowledge after one wait state");
    a_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge longer than one cycle");
    a_upper_zero: assert property (rd |-> avs_readdata[31:6] == '0)
        else $error("unused read bits not zero");
    a_busy_conv: assert property (rd && hit && sense_enable && $past(sense_enable) |-> avs_readdata[4])
        else $error("busy bit low during conversion");
    a_level_read: assert property (rd && hit && $stable(detect_level) |-> avs_readdata[3:0] == detect_level)
        else $error("level field differs from level output");
    a_first_start: assert property ($rose(rst_n) |-> ##[0:3] sense_enable)
        else $error("no first conversion after reset");
    a_conv_len: assert property ($fell(sense_enable) |-> hi_cnt >= DECISION_CYC - 1 && hi_cnt <= DECISION_CYC + 1)
        else $error("conversion length wrong");
    a_level_hold: assert property ($changed(detect_level) |-> $past(sense_enable) || $past(sense_enable, 2))
        else $error("level changed outside conversion end");
    a_auto_period: assert property (auto_sh |-> lo_cnt <= AUTO_CYC + 2)
        else $error("auto sample period exceeded");
    a_cont_repeat: assert property (cont_sh && $fell(sense_enable) ##1 cont_sh |-> ##[0:1] sense_enable)
        else $error("continuous mode did not restart");
endmodule
bind svdc_top svdc_chk #(.DECISION_CYC(DECISION_CYC), .AUTO_CYC(AUTO_CYC)) svdc_chk_i (.*);
`default_nettype wire

// ### tb/svdc_sense.sv
// Behavioural supply detector beside the block
`default_nettype none
module svdc_sense (
    // Clock and control
    input  wire logic       ref_clk,
    input  wire logic       sense_enable,
    input  wire logic [3:0] level_set,
    // Detector result
    output var  logic [3:0] supply_level = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle circuit toggles so a stale capture shows up
    always @(posedge ref_clk) begin
        supply_level <= sense_enable ? level_set : ~supply_level;
    end
endmodule
`default_nettype wire

// ### tb/svdc_bench.sv
// Self-checking bench for the supply detect control block
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("Error %0t got %h exp %h", $time, a, b); end end
module svdc_bench
    import svdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk;
    logic        rst_n;
    logic [19:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [3:0]  supply_level;
    logic        sense_enable;
    logic [3:0]  lvl_set;
    logic [3:0]  exp_lvl;
    logic [3:0]  det_lvl;
    logic        sleep_clear;
    logic [31:0] q;
    int          num_errors = 0;
    int          checks = 0;
    svdc_top #(.DECISION_CYC(20), .AUTO_CYC(50)) svdc_top_i (.ref_clk(ref_clk),
        .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .supply_level(supply_level),
        .sense_enable(sense_enable), .detect_level(det_lvl), .sleep_clear(sleep_clear));
    svdc_sense svdc_sense_i (.ref_clk(ref_clk), .sense_enable(sense_enable),
        .level_set(lvl_set), .supply_level(supply_level));
    // Verdict and stop
    task automatic end_of_test;
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One bus transfer held until acknowledge, then one idle cycle
    task automatic bus(input logic w, input logic [19:0] a, input logic [7:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            end_of_test;
        end
        @(posedge ref_clk);
    endtask
    // Bounded wait for the conversion enable level
    task automatic wait_se(input logic v);
        int n;
        n = 0;
        while (sense_enable !== v && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            end_of_test;
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        rst_n = 1'b0;
        sleep_clear = 1'b0;
        {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
        void'($urandom(32'h71C9));
        lvl_set = 4'($urandom);
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        bus(0, SVDC_CTRL_ADDR, 8'h00, 4'hF);
        `CHK(q[4], 1'b1)
        wait_se(1);
        wait_se(0);
        repeat (2) @(posedge ref_clk);
        exp_lvl = lvl_set;
        bus(0, SVDC_CTRL_ADDR, 8'h00, 4'hF);
        `CHK(q[7:0], {4'h0, exp_lvl})
        `CHK(det_lvl, exp_lvl)
        // Auto mode with unused bits written high
        bus(1, SVDC_CTRL_ADDR, 8'hE0, 4'h1);
        bus(0, SVDC_CTRL_ADDR, 8'h00, 4'hF);
        `CHK(q[7:0], {4'h2, exp_lvl})
        for (int i = 0; i < 3; i++) begin
            lvl_set = 4'($urandom);
            wait_se(1);
            wait_se(0);
            repeat (2) @(posedge ref_clk);
            exp_lvl = lvl_set;
            bus(0, SVDC_CTRL_ADDR, 8'h00, 4'hF);
            `CHK(q[7:0], {4'h2, exp_lvl})
        end
        // Continuous mode: early read keeps old level
        lvl_set = exp_lvl ^ 4'(1 + $urandom % 15);
        bus(1, SVDC_CTRL_ADDR, 8'h10, 4'h1);
        bus(0, SVDC_CTRL_ADDR, 8'h00, 4'hF);
        `CHK(q[7:0], {4'h1, exp_lvl})
        `CHK(det_lvl, exp_lvl)
        repeat (25) @(posedge ref_clk);
        exp_lvl = lvl_set;
        bus(0, SVDC_CTRL_ADDR, 8'h00, 4'hF);
        `CHK(q[7:0], {4'h1, exp_lvl})
        `CHK(det_lvl, exp_lvl)
        bus(1, SVDC_CTRL_ADDR, 8'h00, 4'h1);
        wait_se(0);
        repeat (3) @(posedge ref_clk);
        // Refused writes, unmapped read
        bus(1, SVDC_CTRL_ADDR + 20'h4, 8'h30, 4'h1);
        bus(1, SVDC_CTRL_ADDR, 8'h30, 4'hE);
        bus(0, SVDC_CTRL_ADDR + 20'h4, 8'h00, 4'hF);
        `CHK(q, 32'h0)
        bus(0, SVDC_CTRL_ADDR, 8'h00, 4'hF);
        `CHK(q, {28'h0, exp_lvl})
        // Sleep entry clears the auto bit
        bus(1, SVDC_CTRL_ADDR, 8'h20, 4'h1);
        sleep_clear <= 1'b1;
        @(posedge ref_clk);
        sleep_clear <= 1'b0;
        bus(0, SVDC_CTRL_ADDR, 8'h00, 4'hF);
        `CHK(q[5], 1'b0)
        end_of_test;
    end
endmodule
`default_nettype wire
